// *** epr_regs.svh ***
// Constants for the event pin router and continuous data port.
// Assumes inclusion by bare name from the package and the modules.
`ifndef EPR_REGS_SVH
`define EPR_REGS_SVH
// Field positions of the routing codes in config register a
`define EPR_A_PIN0_LSB 6
`define EPR_A_PIN1_LSB 4
`define EPR_A_PIN2_LSB 2
`define EPR_A_PIN3_LSB 0
// Field position of pin 5 code in config register b
`define EPR_B_PIN5_LSB 4
// Reset values of config registers
`define EPR_CFG_A_RST 8'h00
`define EPR_CFG_B_RST 8'h00
// Fixed framing limits
`define EPR_MAX_PLAIN 8'hFF
`define EPR_MAX_CIPHER 8'h41
`define EPR_MAX_CIPHER_MSG 8'h40
// Bit clock half period on the continuous port
`define EPR_BIT_HALF 16'h0004
`endif

// *** epr_pkg.sv ***
// Types shared by the event pin router files.
// Assumes epr_regs.svh is reachable by bare name.
package epr_pkg;
	`include "epr_regs.svh"
	// ===================================================
	// Operating modes and framing kinds
	typedef enum logic [2:0] {
		EPR_SLEEP, EPR_STDBY, EPR_SYNTH, EPR_RX, EPR_TX
	} epr_mode_t;
	typedef enum logic [1:0] {
		EPR_FRM_FIXED, EPR_FRM_VAR, EPR_FRM_UNLIM
	} epr_frame_t;
endpackage

// *** epr_bitclk.sv ***
// Bit clock generator for the continuous data port.
// Assumes one clock; emits a level clock and edge pulses.
`timescale 1ns/1ps
`include "epr_regs.svh"
module epr_bitclk
	import epr_pkg::*;
#(
	parameter logic [15:0] HALF = `EPR_BIT_HALF
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic run,
	output logic      bclk,
	output logic      rise,
	output logic      fall
);
	logic [15:0] cnt_r;
	// ===================================================
	// Divider; halts low when not running, with one fall pulse if stopped while high
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 16'h0000;
			bclk  <= 1'b0;
			rise  <= 1'b0;
			fall  <= 1'b0;
		end else if (!run) begin
			cnt_r <= 16'h0000;
			rise  <= 1'b0;
			fall  <= bclk;
			bclk  <= 1'b0;
		end else if (cnt_r == HALF - 16'h0001) begin
			cnt_r <= 16'h0000;
			bclk  <= ~bclk;
			rise  <= ~bclk;
			fall  <= bclk;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
			rise  <= 1'b0;
			fall  <= 1'b0;
		end
	end
endmodule // epr_bitclk

// *** epr_router.sv ***
// Event pin router with continuous serial data port and framing select.
// Assumes status inputs come from other clocks or pins and are synchronised here.
`timescale 1ns/1ps
`include "epr_regs.svh"
module epr_router
	import epr_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire epr_mode_t  op_mode,
	input  wire logic       packet_mode,
	input  wire logic [7:0] pin_route_cfg_a,
	input  wire logic [7:0] pin_route_cfg_b,
	input  wire logic       bitsync_cfg,
	input  wire logic       frame_format_sel,
	input  wire logic [7:0] payload_len_cfg,
	input  wire logic       cipher_on,
	input  wire logic       ref_clock_output,
	input  wire logic       synth_locked,
	input  wire logic       mode_settled,
	input  wire logic       auto_seq_active,
	input  wire logic       receiver_up,
	input  wire logic       transmitter_up,
	input  wire logic       signal_level_flag,
	input  wire logic       rx_wait_expired,
	input  wire logic       pattern_match,
	input  wire logic       queue_full,
	input  wire logic       queue_has_data,
	input  wire logic       queue_over_threshold,
	input  wire logic       check_passed,
	input  wire logic       payload_available,
	input  wire logic       frame_sent,
	input  wire logic       demod_raw,
	input  wire logic       pkt_rx_data,
	input  wire logic       event_pin_2_in,
	output logic            event_pin_0,
	output logic            event_pin_1,
	output logic            event_pin_3,
	output logic            event_pin_5,
	output logic            event_pin_2_out,
	output logic            event_pin_2_oe_n,
	output logic            tx_bit,
	output logic            tx_bit_valid,
	output logic            bitsync_on,
	output logic            queue_enable,
	output logic            queue_spi_ok,
	output epr_frame_t      frame_kind,
	output logic            length_byte_on_air,
	output logic            payload_len_bad
);
	localparam int NS = 18;
	// Status vector order
	localparam int S_CLK = 0, S_LCK = 1, S_MRD = 2, S_AUT = 3, S_RXU = 4, S_TXU = 5;
	localparam int S_RSS = 6, S_TMO = 7, S_SYN = 8, S_FFL = 9, S_FNE = 10, S_FLV = 11;
	localparam int S_CRC = 12, S_PRD = 13, S_PST = 14, S_DAT = 15, S_DCK = 16, S_ZRO = 17;

	logic [NS-1:0] st_raw, st_m_r, st_r, st_prev_r;
	logic          din_m_r, din_r;
	logic          data_win_r;
	logic          rx_data_r;
	logic          bclk, brise, bfall;
	logic [4:0]    sel0, sel1, sel2, sel3, sel5;
	logic          is_rx, is_tx, cont, run_clk;

	// ===================================================
	// Input synchronisers: all status lines cross from outside
	assign st_raw = {1'b0, 1'b0, 1'b0, frame_sent, payload_available, check_passed,
		queue_over_threshold, queue_has_data, queue_full, pattern_match, rx_wait_expired,
		signal_level_flag, transmitter_up, receiver_up, auto_seq_active, mode_settled,
		synth_locked, ref_clock_output};
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_m_r    <= '0;
			st_r      <= '0;
			st_prev_r <= '0;
			din_m_r   <= 1'b0;
			din_r     <= 1'b0;
		end else begin
			st_m_r    <= st_raw;
			st_r      <= st_m_r;
			st_prev_r <= st_r;
			din_m_r   <= event_pin_2_in;
			din_r     <= din_m_r;
		end
	end

	assign is_rx   = (op_mode == EPR_RX);
	assign is_tx   = (op_mode == EPR_TX);
	assign cont    = !packet_mode;
	// Bit clock runs in continuous transmit, or in continuous receive with synchronizer on
	assign run_clk = cont && (is_tx || (is_rx && bitsync_cfg));

	epr_bitclk #(
		.HALF (`EPR_BIT_HALF)
	) u_bitclk (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.run     (run_clk),
		.bclk    (bclk),
		.rise    (brise),
		.fall    (bfall)
	);

	// ===================================================
	// Packet receive data window between two rising edges
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_win_r <= 1'b0;
		end else if (!(packet_mode && is_rx)) begin
			data_win_r <= 1'b0;
		end else if (st_r[S_PRD] && !st_prev_r[S_PRD]) begin
			data_win_r <= 1'b0;
		end else if (st_r[S_RXU] && !st_prev_r[S_RXU]) begin
			data_win_r <= 1'b1;
		end
	end

	// ===================================================
	// Receive data: raw or cleaned on bit clock falling edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_data_r <= 1'b0;
		end else if (packet_mode) begin
			rx_data_r <= pkt_rx_data & data_win_r;
		end else if (!bitsync_cfg) begin
			rx_data_r <= demod_raw;
		end else if (bfall) begin
			rx_data_r <= demod_raw;
		end
	end

	// ===================================================
	// Transmit data sampled on each bit clock rising edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_bit       <= 1'b0;
			tx_bit_valid <= 1'b0;
		end else begin
			tx_bit_valid <= cont && is_tx && brise;
			if (cont && is_tx && brise) begin
				tx_bit <= din_r;
			end
		end
	end

	// ===================================================
	// Selection tables; unassigned combinations pick the zero slot
	function automatic logic [4:0] map_sel(input logic pkt, input epr_mode_t m,
			input logic [2:0] pin, input logic [1:0] c);
		logic [4:0] s;
		s = 5'(S_ZRO);
		if (!pkt) begin
			unique case (m)
				EPR_SLEEP, EPR_STDBY, EPR_SYNTH: begin
					if (pin == 3'd3 && c == 2'b10) s = 5'(S_AUT);
					if ((pin == 3'd5 || pin == 3'd0) && c == 2'b11) s = 5'(S_MRD);
					if (m != EPR_SLEEP && pin == 3'd5 && c == 2'b00) s = 5'(S_CLK);
					if (m == EPR_SYNTH && pin == 3'd0 && c == 2'b00) s = 5'(S_LCK);
					if (m == EPR_SYNTH && pin == 3'd1 && c == 2'b11) s = 5'(S_LCK);
				end
				EPR_RX: begin
					unique case (pin)
						3'd5: s = 5'(c == 2'b00 ? S_CLK : c == 2'b01 ? S_RSS : c == 2'b10 ? S_ZRO : S_MRD);
						3'd3: s = 5'(c == 2'b00 ? S_RSS : c == 2'b01 ? S_RXU : c == 2'b10 ? S_AUT : S_TMO);
						3'd1: s = 5'(c == 2'b00 ? S_DCK : c == 2'b01 ? S_RXU : c == 2'b10 ? S_ZRO : S_SYN);
						3'd0: s = 5'(c == 2'b00 ? S_SYN : c == 2'b01 ? S_TMO : c == 2'b10 ? S_RSS : S_MRD);
						default: s = 5'(S_DAT);
					endcase
				end
				EPR_TX: begin
					unique case (pin)
						3'd5: s = 5'(c == 2'b10 ? S_ZRO : c == 2'b11 ? S_MRD : S_CLK);
						3'd3: s = 5'(c == 2'b10 ? S_AUT : S_TXU);
						3'd1: s = 5'(c == 2'b00 ? S_DCK : c == 2'b01 ? S_TXU : c == 2'b10 ? S_ZRO : S_LCK);
						3'd0: s = 5'(c == 2'b00 ? S_LCK : c == 2'b01 ? S_TXU : c == 2'b10 ? S_ZRO : S_MRD);
						default: s = 5'(S_DAT);
					endcase
				end
			endcase
		end else if (m == EPR_RX) begin
			unique case (pin)
				3'd5: s = 5'(c == 2'b00 ? S_CLK : c == 2'b01 ? S_DAT : c == 2'b10 ? S_ZRO : S_MRD);
				3'd3: s = 5'(c == 2'b00 ? S_FFL : c == 2'b01 ? S_RSS : c == 2'b10 ? S_SYN : S_LCK);
				3'd2: s = 5'(c == 2'b00 ? S_FNE : c == 2'b01 ? S_DAT : c == 2'b10 ? S_ZRO : S_AUT);
				3'd1: s = 5'(c == 2'b00 ? S_FLV : c == 2'b01 ? S_FFL : c == 2'b10 ? S_FNE : S_TMO);
				default: s = 5'(c == 2'b00 ? S_CRC : c == 2'b01 ? S_PRD : c == 2'b10 ? S_SYN : S_RSS);
			endcase
		end else if (m == EPR_TX) begin
			unique case (pin)
				3'd5: s = 5'(c == 2'b00 ? S_CLK : c == 2'b01 ? S_DAT : c == 2'b10 ? S_ZRO : S_MRD);
				3'd3: s = 5'(c == 2'b00 ? S_FFL : c == 2'b01 ? S_TXU : c == 2'b10 ? S_ZRO : S_LCK);
				3'd2: s = 5'(c == 2'b00 ? S_FNE : c == 2'b01 ? S_DAT : c == 2'b10 ? S_ZRO : S_AUT);
				3'd1: s = 5'(c == 2'b00 ? S_FLV : c == 2'b01 ? S_FFL : c == 2'b10 ? S_FNE : S_LCK);
				default: s = 5'(c == 2'b00 ? S_PST : c == 2'b01 ? S_TXU : c == 2'b10 ? S_ZRO : S_LCK);
			endcase
		end else begin
			// Packet idle modes: queue flags stay visible while the controller fills or drains it
			if (pin == 3'd3 && c == 2'b00) s = 5'(S_FFL);
			if (pin == 3'd2 && c == 2'b00) s = 5'(S_FNE);
			if (pin == 3'd1) s = 5'(c == 2'b00 ? S_FLV : c == 2'b01 ? S_FFL : c == 2'b10 ? S_FNE : S_ZRO);
			if (pin == 3'd5 && c == 2'b11) s = 5'(S_MRD);
			if (m != EPR_SLEEP && pin == 3'd5 && c == 2'b00) s = 5'(S_CLK);
			if (pin == 3'd2 && c == 2'b11) s = 5'(S_AUT);
			if (m == EPR_SYNTH && c == 2'b11 && pin != 3'd5 && pin != 3'd2) s = 5'(S_LCK);
		end
		return s;
	endfunction

	// Codes taken from the two routing registers
	assign sel0 = map_sel(packet_mode, op_mode, 3'd0, pin_route_cfg_a[`EPR_A_PIN0_LSB +: 2]);
	assign sel1 = map_sel(packet_mode, op_mode, 3'd1, pin_route_cfg_a[`EPR_A_PIN1_LSB +: 2]);
	assign sel2 = map_sel(packet_mode, op_mode, 3'd2, pin_route_cfg_a[`EPR_A_PIN2_LSB +: 2]);
	assign sel3 = map_sel(packet_mode, op_mode, 3'd3, pin_route_cfg_a[`EPR_A_PIN3_LSB +: 2]);
	assign sel5 = map_sel(packet_mode, op_mode, 3'd5, pin_route_cfg_b[`EPR_B_PIN5_LSB +: 2]);

	// ===================================================
	// Registered pin drive; pin 2 tristated when the controller drives it
	logic [NS-1:0] vec;
	assign vec = {1'b0, bclk, rx_data_r, st_r[14:0]};
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			event_pin_0      <= 1'b0;
			event_pin_1      <= 1'b0;
			event_pin_3      <= 1'b0;
			event_pin_5      <= 1'b0;
			event_pin_2_out  <= 1'b0;
			event_pin_2_oe_n <= 1'b1;
		end else begin
			event_pin_0      <= vec[sel0];
			event_pin_1      <= vec[sel1];
			event_pin_3      <= vec[sel3];
			event_pin_5      <= vec[sel5];
			event_pin_2_out  <= vec[sel2];
			// Continuous transmit: input only, so no fight with the controller
			event_pin_2_oe_n <= cont && is_tx;
		end
	end

	// ===================================================
	// Packet engine enables and framing select
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bitsync_on         <= 1'b0;
			queue_enable       <= 1'b0;
			queue_spi_ok       <= 1'b0;
			frame_kind         <= EPR_FRM_UNLIM;
			length_byte_on_air <= 1'b0;
			payload_len_bad    <= 1'b0;
		end else begin
			bitsync_on   <= packet_mode | bitsync_cfg;
			queue_enable <= packet_mode;
			queue_spi_ok <= packet_mode;
			if (frame_format_sel) begin
				frame_kind         <= EPR_FRM_VAR;
				length_byte_on_air <= 1'b1;
			end else if (payload_len_cfg != 8'h00) begin
				frame_kind         <= EPR_FRM_FIXED;
				length_byte_on_air <= 1'b0;
			end else begin
				frame_kind         <= EPR_FRM_UNLIM;
				length_byte_on_air <= 1'b0;
			end
			// Length counts message plus address; with cipher on, fixed framing caps it at 65
			payload_len_bad <= !frame_format_sel && cipher_on
				&& (payload_len_cfg > `EPR_MAX_CIPHER);
		end
	end
endmodule // epr_router

// *** epr_router_sva.sv ***
// Port checker for the event pin router.
// Assumes it is bound onto epr_router and sees only its ports.
`timescale 1ns/1ps
`include "epr_regs.svh"
module epr_router_sva
	import epr_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire epr_mode_t  op_mode,
	input wire logic       packet_mode,
	input wire logic [7:0] pin_route_cfg_a,
	input wire logic       bitsync_cfg,
	input wire logic       frame_format_sel,
	input wire logic [7:0] payload_len_cfg,
	input wire logic       cipher_on,
	input wire logic       event_pin_1,
	input wire logic       event_pin_2_oe_n,
	input wire logic       tx_bit_valid,
	input wire logic       bitsync_on,
	input wire logic       queue_enable,
	input wire logic       queue_spi_ok,
	input wire epr_frame_t frame_kind,
	input wire logic       length_byte_on_air,
	input wire logic       payload_len_bad
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic        past_ok_r;
	logic [14:0] cfg_r;
	logic        steady;
	logic        tx_c;
	logic        rx_raw;
	// ==========
	// Config held over one edge; outputs lag config by one edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			past_ok_r <= 1'h0;
		end else begin
			past_ok_r <= 1'h1;
		end
	end
	// Last edge's config, compared against the present one
	always_ff @(posedge ref_clk) begin
		cfg_r <= {op_mode, packet_mode, frame_format_sel, payload_len_cfg, cipher_on, bitsync_cfg};
	end
	assign steady = past_ok_r && cfg_r == {op_mode, packet_mode, frame_format_sel, payload_len_cfg, cipher_on, bitsync_cfg};
	assign tx_c   = op_mode == EPR_TX && !packet_mode && pin_route_cfg_a[5:4] == 2'h0;
	assign rx_raw = op_mode == EPR_RX && !packet_mode && !bitsync_cfg && pin_route_cfg_a[5:4] == 2'h0;
	// ==========
	// Assertions
	chk_pin2_dir: assert property (steady |-> event_pin_2_oe_n == (op_mode == EPR_TX && !packet_mode))
		else $error("data pin direction wrong");
	chk_sync_force: assert property (steady |-> bitsync_on == (packet_mode || bitsync_cfg))
		else $error("bit synchronizer enable wrong");
	chk_queue_mode: assert property (steady |-> queue_enable == packet_mode)
		else $error("queue enable wrong");
	chk_queue_idle: assert property (steady && packet_mode && (op_mode == EPR_SLEEP || op_mode == EPR_STDBY)
		|-> queue_spi_ok) else $error("queue access blocked");
	chk_frame_fixed: assert property (steady && !frame_format_sel && payload_len_cfg != 8'h00
		|-> frame_kind == EPR_FRM_FIXED && !length_byte_on_air) else $error("fixed framing wrong");
	chk_frame_var: assert property (steady && frame_format_sel |-> frame_kind == EPR_FRM_VAR)
		else $error("variable framing wrong");
	chk_len_limit: assert property (steady |-> payload_len_bad == (!frame_format_sel && cipher_on && payload_len_cfg > `EPR_MAX_CIPHER))
		else $error("length flag wrong");
	chk_bclk_high: assert property ($fell(event_pin_1) && tx_c && $past(rst_n, 5)
		|-> $past(event_pin_1, 4) && !$past(event_pin_1, 5)) else $error("bit clock high time wrong");
	chk_sample_once: assert property (tx_bit_valid |=> !tx_bit_valid [*7])
		else $error("bit sampled too often");
	chk_no_rx_clk: assert property (rx_raw && $past(rx_raw) && $past(rx_raw, 2) && $past(rst_n, 2) |-> !event_pin_1)
		else $error("bit clock without synchronizer");
	cov_tx_bit: cover property (tx_bit_valid);
	cov_pkt_rx: cover property (packet_mode && op_mode == EPR_RX);
	cov_len_bad: cover property (payload_len_bad);
endmodule // epr_router_sva
bind epr_router epr_router_sva chk_u (.*);

// *** epr_ctrl_model.sv ***
// Controller model on the continuous data port.
// Assumes the data wire level is resolved by the bench.
`timescale 1ns/1ps
module epr_ctrl_model (
	input  wire logic ref_clk,
	input  wire logic bclk,
	input  wire logic rx_data,
	output logic       tx_data,
	output logic [7:0] rx_shift
);
	logic [7:0] pat_r;
	logic       bclk_r;
	initial begin
		pat_r = 8'hB4;
		tx_data = 1'h0;
		bclk_r = 1'h0;
		rx_shift = 8'h00;
	end
	// ==========
	// Data moves on the clock fall, well clear of the sampling rise
	always @(posedge ref_clk) begin
		bclk_r <= bclk;
		if (bclk_r && !bclk) begin
			pat_r   <= {pat_r[6:0], pat_r[7]};
			tx_data <= pat_r[7];
		end
		if (!bclk_r && bclk) begin
			rx_shift <= {rx_shift[6:0], rx_data};
		end
	end
endmodule // epr_ctrl_model

// *** epr_router_tb_top.sv ***
// Self-checking bench for the event pin router.
// Assumes the package, checker and controller model are compiled first.
`timescale 1ns/1ps
`define CMP(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module epr_router_tb_top
	import epr_pkg::*;
;
	logic ref_clk, rst_n, packet_mode, bitsync_cfg, frame_format_sel, cipher_on, demod_raw, pkt_rx_data;
	logic event_pin_0, event_pin_1, event_pin_3, event_pin_5, event_pin_2_out, event_pin_2_oe_n;
	logic tx_bit, tx_bit_valid, bitsync_on, queue_enable, queue_spi_ok, length_byte_on_air, payload_len_bad;
	logic [7:0] pin_route_cfg_a, pin_route_cfg_b, payload_len_cfg, rx_shift;
	logic [14:0] st;
	logic tx_data;
	epr_mode_t op_mode;
	epr_frame_t frame_kind;
	wire logic ref_clock_output, synth_locked, mode_settled, auto_seq_active, receiver_up, transmitter_up;
	wire logic signal_level_flag, rx_wait_expired, pattern_match, queue_full, queue_has_data;
	wire logic queue_over_threshold, check_passed, payload_available, frame_sent, event_pin_2_in;
	int miscompares, compares;
	// Expected source per pin 5,3,2,1,0; F means held low
	localparam logic [19:0] MAP [40] = '{
		20'hFFFFF, 20'hFFFFF, 20'hF3FFF, 20'h2FFF2, 20'h0FFFF, 20'hFFFFF, 20'hF3FFF, 20'h2FFF2,
		20'h0FFF1, 20'hFFFFF, 20'hF3FFF, 20'h2FF12, 20'h06FF8, 20'h64F47, 20'hF3FF6, 20'h27F82,
		20'h05FF1, 20'h05F55, 20'hF3FFF, 20'h25F12, 20'hF9ABF, 20'hFFF9F, 20'hFFFAF, 20'h2F3FF,
		20'h09ABF, 20'hFFF9F, 20'hFFFAF, 20'h2F3FF, 20'h09ABF, 20'hFFF9F, 20'hFFFAF, 20'h21311,
		20'h09ABC, 20'hF6F9D, 20'hF8FA8, 20'h21376, 20'h09ABE, 20'hF5F95, 20'hFFFAF, 20'h21311};
	// ==========
	// Status vector fans out by index; the data wire is resolved from the enable
	assign {frame_sent, payload_available, check_passed, queue_over_threshold, queue_has_data, queue_full,
		pattern_match, rx_wait_expired, signal_level_flag, transmitter_up, receiver_up, auto_seq_active,
		mode_settled, synth_locked, ref_clock_output} = st;
	assign event_pin_2_in = event_pin_2_oe_n ? tx_data : event_pin_2_out;
	epr_router dut_u (.*);
	epr_ctrl_model ctl_u (.ref_clk(ref_clk), .bclk(event_pin_1), .rx_data(event_pin_2_in), .tx_data(tx_data),
		.rx_shift(rx_shift));
	// Clock at 40 MHz
	initial begin
		ref_clk = 1'h0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			#1;
		end
	endtask
	task automatic pin_ck(input logic v, input logic [3:0] ix, input bit sk);
		if (!sk) `CMP(v, ix == 4'hF ? 1'h0 : st[ix])
	endtask
	task automatic cfg_ck(input logic f, input logic [7:0] l, input logic ci, input epr_frame_t k, input logic b);
		frame_format_sel = f;
		payload_len_cfg = l;
		cipher_on = ci;
		tick(2);
		`CMP({frame_kind, payload_len_bad, length_byte_on_air}, {k, b, f})
	endtask
	task automatic test_done();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Hang guard, far beyond the few thousand cycles the tests need
	initial begin
		#(25 * 12000);
		miscompares++;
		test_done();
	end
	// ==========
	// Test sequence
	initial begin
		logic [19:0] ent;
		logic [1:0] cr;
		bit sk;
		int n;
		{rst_n, packet_mode, bitsync_cfg, frame_format_sel, cipher_on, demod_raw, pkt_rx_data} = 7'h00;
		op_mode = EPR_SLEEP;
		{pin_route_cfg_a, pin_route_cfg_b, payload_len_cfg, st} = 39'h0;
		tick(19);
		`CMP({event_pin_2_oe_n, frame_kind, event_pin_0, tx_bit_valid}, {1'h1, EPR_FRM_UNLIM, 2'h0})
		tick(1);
		rst_n = 1'h1;
		$display("test reset done");
		for (int p = 0; p < 2; p++) for (int m = 0; m < 5; m++) for (int c = 0; c < 4; c++) begin
			packet_mode = p[0];
			op_mode = epr_mode_t'(m);
			cr = c[1:0];
			pin_route_cfg_a = {4{cr}};
			pin_route_cfg_b = {2'h0, cr, 4'h0};
			ent = MAP[p * 20 + m * 4 + c];
			sk = p == 1 && c == 1 && m >= 3;
			for (int b = -1; b < 15; b++) begin
				st = (b < 0) ? 15'h0 : 15'h1 << b;
				tick(4);
				pin_ck(event_pin_5, ent[19:16], sk);
				pin_ck(event_pin_3, ent[15:12], 1'b0);
				pin_ck(event_pin_2_out, ent[11:8], sk || p == 0);
				pin_ck(event_pin_1, ent[7:4], p == 0 && c == 0 && m == 4);
				pin_ck(event_pin_0, ent[3:0], 1'b0);
			end
		end
		$display("test mapping done");
		{packet_mode, pin_route_cfg_a, pin_route_cfg_b, st} = 32'h0;
		op_mode = EPR_TX;
		for (int i = 0; i < 12; i++) begin
			n = 0;
			while (tx_bit_valid !== 1'h1 && n < 20) begin
				tick(1);
				n++;
			end
			`CMP({n < 20, tx_bit, event_pin_2_oe_n}, {1'h1, tx_data, 1'h1})
			tick(1);
		end
		$display("test tx stream done");
		op_mode = EPR_RX;
		demod_raw = 1'h1;
		tick(4);
		`CMP(event_pin_2_out, 1'h1)
		demod_raw = 1'h0;
		tick(4);
		`CMP({event_pin_2_oe_n, event_pin_2_out, event_pin_1}, 3'h0)
		bitsync_cfg = 1'h1;
		demod_raw = 1'h1;
		tick(60);
		`CMP(rx_shift[3:0], 4'hF)
		demod_raw = 1'h0;
		tick(60);
		`CMP(rx_shift[3:0], 4'h0)
		$display("test rx stream done");
		{bitsync_cfg, packet_mode, pkt_rx_data} = 3'h3;
		pin_route_cfg_a = 8'h55;
		pin_route_cfg_b = 8'h10;
		tick(6);
		`CMP({event_pin_5, event_pin_2_out, event_pin_0}, 3'h0)
		st[4] = 1'h1;
		tick(6);
		`CMP({event_pin_5, event_pin_2_out, event_pin_0}, 3'h6)
		st[13] = 1'h1;
		tick(6);
		`CMP({event_pin_5, event_pin_2_out, event_pin_0}, 3'h1)
		op_mode = EPR_SLEEP;
		tick(2);
		`CMP({queue_enable, queue_spi_ok, bitsync_on}, 3'h7)
		op_mode = EPR_STDBY;
		tick(2);
		`CMP({queue_enable, queue_spi_ok, bitsync_on}, 3'h7)
		$display("test packet done");
		cfg_ck(1'h0, 8'h01, 1'h0, EPR_FRM_FIXED, 1'h0);
		cfg_ck(1'h0, 8'hFF, 1'h0, EPR_FRM_FIXED, 1'h0);
		cfg_ck(1'h0, 8'h41, 1'h1, EPR_FRM_FIXED, 1'h0);
		cfg_ck(1'h0, 8'h42, 1'h1, EPR_FRM_FIXED, 1'h1);
		cfg_ck(1'h1, 8'h42, 1'h0, EPR_FRM_VAR, 1'h0);
		cfg_ck(1'h0, 8'h00, 1'h0, EPR_FRM_UNLIM, 1'h0);
		$display("test framing done");
		test_done();
	end
endmodule // epr_router_tb_top
